// file: hdl/ecgfoc_map.svh
// Register offsets, field positions, reset values and timing constants
`ifndef ECGFOC_MAP_SVH
`define ECGFOC_MAP_SVH

// ==========================================================================
// Serial command word layout
`define ECGFOC_CMD_WR_BIT      31
`define ECGFOC_CMD_ADDR_HI     30
`define ECGFOC_CMD_ADDR_LO     24
`define ECGFOC_WORD_BITS       32
`define ECGFOC_CNT_LAST        5'h1F

// ==========================================================================
// Register offsets and reset values
`define ECGFOC_ADDR_FRAME      7'h0A
`define ECGFOC_ADDR_FILTER     7'h0B
`define ECGFOC_FRAME_RST       24'h079000
`define ECGFOC_FILTER_RST      24'h000000

// ==========================================================================
// Frame format control fields
`define ECGFOC_F_CHAN1_EXCL    23
`define ECGFOC_F_CHAN2_EXCL    22
`define ECGFOC_F_CHAN3_EXCL    21
`define ECGFOC_F_PACE_EXCL     14
`define ECGFOC_F_RMAG_EXCL     13
`define ECGFOC_F_RPH_EXCL      12
`define ECGFOC_F_EOFF_EXCL     11
`define ECGFOC_F_PIN_EXCL      10
`define ECGFOC_F_CHK_EXCL      9
`define ECGFOC_F_AUTO_DROP     7
`define ECGFOC_F_HDR_REPEAT    6
`define ECGFOC_F_FORMAT        4
`define ECGFOC_F_SKIP_HI       3
`define ECGFOC_F_SKIP_LO       2
`define ECGFOC_F_RATE_HI       1
`define ECGFOC_F_RATE_LO       0

// ==========================================================================
// Filter select control fields
`define ECGFOC_L_MASTER_NOTCH  5
`define ECGFOC_L_NOTCH_BYPASS  4
`define ECGFOC_L_LPF_HI        3
`define ECGFOC_L_LPF_LO        2

// ==========================================================================
// Frame word slots, in transmit order
`define ECGFOC_NUM_WORDS       10
`define ECGFOC_W_HEADER        4'h0
`define ECGFOC_W_LAST          4'h9

// ==========================================================================
// Timing: clock and output frame rates
`define ECGFOC_CLK_HZ          64'd10000000
`define ECGFOC_RATE_2K_HZ      64'd2000
`define ECGFOC_RATE_16K_HZ     64'd16000
`define ECGFOC_RATE_128K_HZ    64'd128000
`define ECGFOC_RATE_LOW_MHZ    64'd31250
`define ECGFOC_MHZ_PER_HZ      64'd1000

`endif

// file: hdl/ecgfoc_pkg.sv
// Types shared by the frame output control block
package ecgfoc_pkg;

  // ========================================================================
  // Output frame rate selections, in field code order
  typedef enum logic [1:0] {
    ECGFOC_RATE_2K,
    ECGFOC_RATE_16K,
    ECGFOC_RATE_128K,
    ECGFOC_RATE_LOW
  } ecgfoc_rate_t;

  // ========================================================================
  // Serial link state
  typedef enum logic {
    ECGFOC_LINK_IDLE,
    ECGFOC_LINK_ACTIVE
  } ecgfoc_link_t;

  // ========================================================================
  // One frame's worth of words and header flags from the acquisition core
  typedef struct packed {
    logic        ready;
    logic        pace_flag;
    logic        resp_flag;
    logic        eoff_flag;
    logic [31:0] header;
    logic [31:0] chan1;
    logic [31:0] chan2;
    logic [31:0] chan3;
    logic [31:0] pace;
    logic [31:0] resp_mag;
    logic [31:0] resp_phase;
    logic [31:0] eoff;
    logic [31:0] pin_state;
    logic [31:0] check;
  } ecgfoc_frame_t;

  // ========================================================================
  // Settings handed to the acquisition and filter path
  typedef struct packed {
    logic         electrode_fmt;
    ecgfoc_rate_t frame_rate;
    logic         notch_on;
    logic [1:0]   lowpass_corner;
  } ecgfoc_cfg_t;

endpackage

// file: hdl/ecgfoc_rate_gen.sv
// Output frame rate divider with frame decimation
module ecgfoc_rate_gen #(
  parameter int unsigned DIV_2K   = 5000,
  parameter int unsigned DIV_16K  = 625,
  parameter int unsigned DIV_128K = 78,
  parameter int unsigned DIV_LOW  = 320000
) (
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire ecgfoc_pkg::ecgfoc_rate_t rate,
  input  wire logic [1:0]           skip,
  input  wire logic                 restart,
  output logic                      frame_tick
);
  import ecgfoc_pkg::*;

  localparam int unsigned CW = $clog2(DIV_LOW + 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic [CW-1:0] limit;
  logic [1:0]    skip_q;
  logic          raw_tick;
  logic          keep;

  // ========================================================================
  // Base rate
  assign limit = (rate == ECGFOC_RATE_2K)   ? CW'(DIV_2K - 1)   :
                 (rate == ECGFOC_RATE_16K)  ? CW'(DIV_16K - 1)  :
                 (rate == ECGFOC_RATE_128K) ? CW'(DIV_128K - 1) :
                                              CW'(DIV_LOW - 1);
  // Compare with >= so a shorter rate chosen mid-count wraps at once
  assign raw_tick = (cnt_q >= limit);
  assign cnt_d    = (raw_tick || restart) ? '0 : cnt_q + CW'(1);

  // ========================================================================
  // Decimation: every frame, every second, or every fourth
  assign keep = (skip == 2'h0) ||
                (skip == 2'h1 && !skip_q[0]) ||
                (skip[1] && skip_q == 2'h0);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_q      <= '0;
      skip_q     <= 2'h0;
      frame_tick <= 1'b0;
    end else begin
      cnt_q      <= cnt_d;
      frame_tick <= raw_tick && !restart && keep;
      if (restart) begin
        skip_q <= 2'h0;
      end else if (raw_tick) begin
        skip_q <= skip_q + 2'h1;
      end
    end
  end

endmodule

// file: hdl/ecgfoc_top.sv
// Frame output control: serial register access and frame word sequencing
// Operation
// - Each exclusion bit set drops its word from the frame; clear keeps it.
// - Kept channel word with electrode off carries undefined content.
// - Respiration phase exclusion resets to one, so phase word absent.
// - Auto drop omits pace, resp magnitude, lead-off words if flags clear.
// - Header repeat with data not ready sends only the header until ready.
// - Format bit picks lead or electrode words; lead only at 2k, 16k.
// - Skip field outputs every frame, every second, or every fourth frame.
// - Rate field selects 2 kHz, 16 kHz, 128 kHz or 31.25 Hz.
// - As link master, notch bit five clear bypasses, set inserts notch.
// - Notch bypass bit four clear keeps notch, set bypasses it.
// - Low-pass field selects 40, 150, 250 or 450 Hz corner.
`include "ecgfoc_map.svh"
module ecgfoc_top #(
  parameter int unsigned DIV_2K   =
    int'(`ECGFOC_CLK_HZ / `ECGFOC_RATE_2K_HZ),
  parameter int unsigned DIV_16K  =
    int'(`ECGFOC_CLK_HZ / `ECGFOC_RATE_16K_HZ),
  parameter int unsigned DIV_128K =
    int'(`ECGFOC_CLK_HZ / `ECGFOC_RATE_128K_HZ),
  parameter int unsigned DIV_LOW  =
    int'(`ECGFOC_CLK_HZ * `ECGFOC_MHZ_PER_HZ / `ECGFOC_RATE_LOW_MHZ)
) (
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  sclk,
  input  wire logic                  cs_n,
  input  wire logic                  sdi,
  input  wire logic                  is_master,
  input  wire ecgfoc_pkg::ecgfoc_frame_t frame_in,
  output logic                       sdo,
  output logic                       frame_request,
  output ecgfoc_pkg::ecgfoc_cfg_t    cfg
);
  import ecgfoc_pkg::*;

  localparam int NW = `ECGFOC_NUM_WORDS;

  // ========================================================================
  // Pin synchronisers
  logic [3:0]   meta_q;
  logic [3:0]   sync_q;
  logic         sclk_prev_q;
  logic         cs_prev_q;
  logic         sclk_s;
  logic         cs_n_s;
  logic         sdi_s;
  logic         master_s;
  logic         sclk_rise;
  logic         sclk_fall;
  logic         cs_fall;

  assign sclk_s    = sync_q[0];
  assign cs_n_s    = sync_q[1];
  assign sdi_s     = sync_q[2];
  assign master_s  = sync_q[3];
  assign sclk_rise = sclk_s && !sclk_prev_q;
  assign sclk_fall = !sclk_s && sclk_prev_q;
  assign cs_fall   = !cs_n_s && cs_prev_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_q      <= 4'h2;
      sync_q      <= 4'h2;
      sclk_prev_q <= 1'b0;
      cs_prev_q   <= 1'b1;
    end else begin
      meta_q      <= {is_master, sdi, cs_n, sclk};
      sync_q      <= meta_q;
      sclk_prev_q <= sclk_s;
      cs_prev_q   <= cs_n_s;
    end
  end

  // ========================================================================
  // Serial shifter
  ecgfoc_link_t link_q;
  logic [4:0]   bit_cnt_q;
  logic [31:0]  cmd_sr_q;
  logic [31:0]  out_sr_q;
  logic         skip_fall_q;
  logic [31:0]  cmd_word;
  logic         word_done;
  logic         cmd_wr;
  logic [6:0]   cmd_addr;
  logic         hit_frame;
  logic         hit_filter;
  logic         load;
  logic [31:0]  load_word;

  assign cmd_word  = {cmd_sr_q[30:0], sdi_s};
  assign word_done = (link_q == ECGFOC_LINK_ACTIVE) && sclk_rise &&
                     (bit_cnt_q == `ECGFOC_CNT_LAST);
  assign cmd_wr    = cmd_word[`ECGFOC_CMD_WR_BIT];
  assign cmd_addr  = cmd_word[`ECGFOC_CMD_ADDR_HI:`ECGFOC_CMD_ADDR_LO];
  // Addresses of neighbouring registers are left to their own blocks
  assign hit_frame  = word_done && (cmd_addr == `ECGFOC_ADDR_FRAME);
  assign hit_filter = word_done && (cmd_addr == `ECGFOC_ADDR_FILTER);
  assign load       = cs_fall || word_done;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      link_q <= ECGFOC_LINK_IDLE;
    end else begin
      case (link_q)
        ECGFOC_LINK_IDLE: begin
          if (cs_fall) begin
            link_q <= ECGFOC_LINK_ACTIVE;
          end
        end
        ECGFOC_LINK_ACTIVE: begin
          if (cs_n_s) begin
            link_q <= ECGFOC_LINK_IDLE;
          end
        end
        default: begin
          link_q <= ECGFOC_LINK_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bit_cnt_q <= 5'h0;
      cmd_sr_q  <= 32'h0;
    end else if (cs_fall) begin
      bit_cnt_q <= 5'h0;
    end else if (link_q == ECGFOC_LINK_ACTIVE && sclk_rise) begin
      bit_cnt_q <= bit_cnt_q + 5'h1;
      cmd_sr_q  <= cmd_word;
    end
  end

  // A word loaded on the last rising edge must survive the falling edge
  // that follows, so that edge does not shift
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      out_sr_q    <= 32'h0;
      sdo         <= 1'b0;
      skip_fall_q <= 1'b0;
    end else if (load) begin
      out_sr_q    <= load_word;
      sdo         <= load_word[31];
      skip_fall_q <= word_done;
    end else if (link_q == ECGFOC_LINK_ACTIVE && sclk_fall) begin
      skip_fall_q <= 1'b0;
      if (!skip_fall_q) begin
        out_sr_q <= {out_sr_q[30:0], 1'b0};
        sdo      <= out_sr_q[30];
      end
    end else if (cs_n_s) begin
      sdo <= 1'b0;
    end
  end

  // ========================================================================
  // Registers
  // Reserved fields are stored as written; keeping them is software's job
  logic [23:0]  frame_ctl_q;
  logic [23:0]  filter_ctl_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      frame_ctl_q  <= `ECGFOC_FRAME_RST;
      filter_ctl_q <= `ECGFOC_FILTER_RST;
    end else begin
      if (hit_frame && cmd_wr) begin
        frame_ctl_q <= cmd_word[23:0];
      end
      if (hit_filter && cmd_wr) begin
        filter_ctl_q <= cmd_word[23:0];
      end
    end
  end

  // ========================================================================
  // Configuration decode
  ecgfoc_rate_t rate;
  logic [1:0]   skip;
  logic         auto_drop;
  logic         hdr_repeat;
  logic         lead_ok;
  ecgfoc_cfg_t  cfg_d;

  assign rate = ecgfoc_rate_t'(
    frame_ctl_q[`ECGFOC_F_RATE_HI:`ECGFOC_F_RATE_LO]);
  assign skip = frame_ctl_q[`ECGFOC_F_SKIP_HI:`ECGFOC_F_SKIP_LO];
  assign auto_drop  = frame_ctl_q[`ECGFOC_F_AUTO_DROP];
  assign hdr_repeat = frame_ctl_q[`ECGFOC_F_HDR_REPEAT];
  // Lead words are not produced at the fast and slow rates, so electrode
  // format is forced there even if software left the bit clear
  assign lead_ok = (rate == ECGFOC_RATE_2K) ||
                   (rate == ECGFOC_RATE_16K);
  assign cfg_d.electrode_fmt = frame_ctl_q[`ECGFOC_F_FORMAT] ||
                               !lead_ok;
  assign cfg_d.frame_rate    = rate;
  assign cfg_d.notch_on = master_s ?
    filter_ctl_q[`ECGFOC_L_MASTER_NOTCH] :
    !filter_ctl_q[`ECGFOC_L_NOTCH_BYPASS];
  assign cfg_d.lowpass_corner =
    filter_ctl_q[`ECGFOC_L_LPF_HI:`ECGFOC_L_LPF_LO];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg <= '0;
    end else begin
      cfg <= cfg_d;
    end
  end

  // ========================================================================
  // Frame timing
  logic frame_tick;

  ecgfoc_rate_gen #(
    .DIV_2K   (DIV_2K),
    .DIV_16K  (DIV_16K),
    .DIV_128K (DIV_128K),
    .DIV_LOW  (DIV_LOW)
  ) u_rate (
    .clock      (clock),
    .rst        (rst),
    .rate       (rate),
    .skip       (skip),
    .restart    (hit_frame && cmd_wr),
    .frame_tick (frame_tick)
  );

  // ========================================================================
  // Frame snapshot and word selection
  logic [31:0]  words_in [NW];
  logic [31:0]  snap_q   [NW];
  logic [3:0]   flags_q;
  logic [3:0]   ptr_q;
  logic         pend_q;
  logic         tick_pend_q;
  logic         latch;
  logic [NW-1:0] excl;
  logic [NW-1:0] dropped;
  logic [NW-1:0] incl;
  logic [3:0]   nxt;
  logic         nxt_none;
  logic         hold_hdr;

  // Channel words pass through as the core gives them; with an electrode
  // off their content is undefined and is not patched here
  assign words_in[0] = frame_in.header;
  assign words_in[1] = frame_in.chan1;
  assign words_in[2] = frame_in.chan2;
  assign words_in[3] = frame_in.chan3;
  assign words_in[4] = frame_in.pace;
  assign words_in[5] = frame_in.resp_mag;
  assign words_in[6] = frame_in.resp_phase;
  assign words_in[7] = frame_in.eoff;
  assign words_in[8] = frame_in.pin_state;
  assign words_in[9] = frame_in.check;

  assign excl = {frame_ctl_q[`ECGFOC_F_CHK_EXCL],
                 frame_ctl_q[`ECGFOC_F_PIN_EXCL],
                 frame_ctl_q[`ECGFOC_F_EOFF_EXCL],
                 frame_ctl_q[`ECGFOC_F_RPH_EXCL],
                 frame_ctl_q[`ECGFOC_F_RMAG_EXCL],
                 frame_ctl_q[`ECGFOC_F_PACE_EXCL],
                 frame_ctl_q[`ECGFOC_F_CHAN3_EXCL],
                 frame_ctl_q[`ECGFOC_F_CHAN2_EXCL],
                 frame_ctl_q[`ECGFOC_F_CHAN1_EXCL],
                 1'b0};
  // flags_q holds {ready, pace, resp, eoff}
  assign dropped = {2'b00, !flags_q[0], 1'b0, !flags_q[1], !flags_q[2],
                    4'h0} & {NW{auto_drop}};
  assign incl = ~(excl | dropped);

  // Next kept slot after the current one; removed slots are passed over
  always_comb begin
    nxt = `ECGFOC_W_HEADER;
    nxt_none = 1'b1;
    for (int k = NW - 1; k > 0; k--) begin
      if (incl[k] && 4'(k) > ptr_q) begin
        nxt = 4'(k);
        nxt_none = 1'b0;
      end
    end
  end

  assign hold_hdr = pend_q && (ptr_q == `ECGFOC_W_HEADER) &&
                    hdr_repeat && !flags_q[3];
  assign latch = tick_pend_q && (ptr_q == `ECGFOC_W_HEADER) && !load;
  // A read answer preempts the frame; with no frame pending the last
  // header is resent so the host still sees the not-ready state
  assign load_word = (word_done && !cmd_wr && hit_frame) ?
                       {1'b0, `ECGFOC_ADDR_FRAME, frame_ctl_q} :
                     (word_done && !cmd_wr && hit_filter) ?
                       {1'b0, `ECGFOC_ADDR_FILTER, filter_ctl_q} :
                     pend_q ? snap_q[ptr_q] :
                              snap_q[0];

  for (genvar g = 0; g < NW; g++) begin : g_snap
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        snap_q[g] <= 32'h0;
      end else if (latch) begin
        snap_q[g] <= words_in[g];
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flags_q       <= 4'h0;
      ptr_q         <= `ECGFOC_W_HEADER;
      pend_q        <= 1'b0;
      tick_pend_q   <= 1'b0;
      frame_request <= 1'b0;
    end else begin
      frame_request <= frame_tick;
      if (frame_tick) begin
        tick_pend_q <= 1'b1;
      end else if (latch) begin
        tick_pend_q <= 1'b0;
      end
      if (latch) begin
        flags_q <= {frame_in.ready, frame_in.pace_flag,
                    frame_in.resp_flag, frame_in.eoff_flag};
        pend_q  <= 1'b1;
      end else if (load && pend_q && !(word_done && !cmd_wr &&
                   (hit_frame || hit_filter)) && !hold_hdr) begin
        if (nxt_none) begin
          pend_q <= 1'b0;
          ptr_q  <= `ECGFOC_W_HEADER;
        end else begin
          ptr_q  <= nxt;
        end
      end
    end
  end

endmodule

// file: verification/ecgfoc_monitor.sv
// Port checker for the frame output control block
module ecgfoc_monitor #(
  parameter int unsigned DIV_2K   = 5000,
  parameter int unsigned DIV_16K  = 625,
  parameter int unsigned DIV_128K = 78,
  parameter int unsigned DIV_LOW  = 320000
) (
  input wire logic                     clock,
  input wire logic                     rst,
  input wire logic                     sclk,
  input wire logic                     cs_n,
  input wire logic                     sdi,
  input wire logic                     is_master,
  input wire ecgfoc_pkg::ecgfoc_frame_t frame_in,
  input wire logic                     sdo,
  input wire logic                     frame_request,
  input wire ecgfoc_pkg::ecgfoc_cfg_t  cfg
);
  timeunit 1ns;
  timeprecision 1ns;
  import ecgfoc_pkg::*;
  // ==========================================================================
  // Request spacing, trusted only while no select period can restart it
  logic [23:0] gap_q;
  logic        valid_q;
  logic [23:0] div_w;
  assign div_w = (cfg.frame_rate == ECGFOC_RATE_2K)   ? 24'(DIV_2K)   :
                 (cfg.frame_rate == ECGFOC_RATE_16K)  ? 24'(DIV_16K)  :
                 (cfg.frame_rate == ECGFOC_RATE_128K) ? 24'(DIV_128K) :
                 24'(DIV_LOW);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gap_q   <= 24'h0;
      valid_q <= 1'b0;
    end else begin
      gap_q   <= frame_request ? 24'h1 : gap_q + 24'h1;
      valid_q <= cs_n && (valid_q || frame_request);
    end
  end
  // ==========================================================================
  // Assertions
  default clocking mon_cb @(posedge clock); endclocking
  default disable iff (rst);
  AST_REQ_PULSE: assert property (frame_request |=> !frame_request)
    else $error("frame request held over one cycle");
  AST_GAP_MIN: assert property (
    frame_request && valid_q |-> gap_q >= div_w)
    else $error("frame requests closer than the rate period");
  AST_GAP_SKIP: assert property (frame_request && valid_q |->
    gap_q == div_w || gap_q == 2 * div_w || gap_q == 4 * div_w)
    else $error("frame request spacing not a decimation step");
  AST_GAP_MAX: assert property (valid_q |-> gap_q <= 4 * div_w)
    else $error("frame request missing");
  AST_FMT_128K: assert property (
    cfg.frame_rate == ECGFOC_RATE_128K |-> cfg.electrode_fmt)
    else $error("lead format at the fast rate");
  AST_FMT_LOW: assert property (
    cfg.frame_rate == ECGFOC_RATE_LOW |-> cfg.electrode_fmt)
    else $error("lead format at the slow rate");
  AST_SDO_IDLE: assert property (cs_n [*5] |-> !sdo)
    else $error("serial output driven while deselected");
  AST_CFG_HOLD: assert property (
    (cs_n && $stable(is_master)) [*6] |=> $stable(cfg))
    else $error("settings changed without a write");
  COV_FAST: cover property (
    frame_request && cfg.frame_rate == ECGFOC_RATE_128K);
  COV_NOTCH: cover property ($rose(cfg.notch_on));
  COV_TALK: cover property (!cs_n && sdo);
endmodule

bind ecgfoc_top ecgfoc_monitor #(
  .DIV_2K(DIV_2K), .DIV_16K(DIV_16K), .DIV_128K(DIV_128K), .DIV_LOW(DIV_LOW)
) mon_u (
  .clock(clock), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
  .is_master(is_master), .frame_in(frame_in), .sdo(sdo),
  .frame_request(frame_request), .cfg(cfg)
);

// file: verification/ecgfoc_host.sv
// Host controller model on the serial register link
module ecgfoc_host (
  input  wire logic clock,
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Link clock stands still low outside words, 8 system clocks a period
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic open_sel();
    cs_n <= 1'b0;
    tick(8);
  endtask
  task automatic close_sel();
    tick(4);
    cs_n <= 1'b1;
    // Released data line must not keep its last level
    sdi  <= ~sdi;
    tick(8);
  endtask
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    for (int i = 31; i >= 0; i--) begin
      sdi  <= tx[i];
      tick(4);
      rx[i] = sdo;
      sclk <= 1'b1;
      tick(4);
      sclk <= 1'b0;
    end
  endtask
  task automatic extra_clocks();
    repeat (4) begin
      tick(4);
      sclk <= 1'b1;
      tick(4);
      sclk <= 1'b0;
    end
  endtask
endmodule

// file: verification/test_ecg_frame_output_control.sv
// Self-checking bench for the frame output control block
`include "ecgfoc_map.svh"
`define CHK(what, exp, got) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("wrong value %s expected %h seen %h", what, exp, got); \
    end \
  end
module test_ecg_frame_output_control;
  timeunit 1ns;
  timeprecision 1ns;
  import ecgfoc_pkg::*;
  // Short dividers keep the run brief; all gaps derive from them
  localparam int         DV [4] = '{20, 10, 5, 40};
  localparam logic [6:0] AF     = `ECGFOC_ADDR_FRAME;
  localparam logic [6:0] AL     = `ECGFOC_ADDR_FILTER;
  logic          clock;
  logic          rst;
  logic          sclk;
  logic          cs_n;
  logic          sdi;
  logic          is_master;
  ecgfoc_frame_t frame_in;
  logic          sdo;
  logic          frame_request;
  ecgfoc_cfg_t   cfg;
  int            n_errors;
  int            compares;
  int            cycles;
  logic [31:0]   r;
  ecgfoc_top #(
    .DIV_2K(DV[0]), .DIV_16K(DV[1]), .DIV_128K(DV[2]), .DIV_LOW(DV[3])
  ) dut_u (
    .clock(clock), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .is_master(is_master), .frame_in(frame_in), .sdo(sdo),
    .frame_request(frame_request), .cfg(cfg)
  );
  ecgfoc_host host_u (
    .clock(clock), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo)
  );
  // ==========================================================================
  // Clock, watchdog and verdict
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 90000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ==========================================================================
  // Helpers
  function automatic logic [31:0] wv(input int i);
    return 32'h11111111 * (i + 1);
  endfunction
  function automatic logic [23:0] fctl(input logic [23:0] v);
    return (v & ~24'h1F8120) | 24'h1F8000;
  endfunction
  function automatic int build(input logic [23:0] c, input logic [2:0] f,
                               input logic rdy, output logic [31:0] e [10]);
    int   pos [10];
    int   m;
    logic drop;
    pos = '{0, 23, 22, 21, 14, 13, 12, 11, 10, 9};
    m = 1;
    e[0] = wv(0);
    if (c[6] && !rdy)
      return 1;
    for (int i = 1; i < 10; i++) begin
      drop = c[pos[i]] || (c[7] && ((i == 4 && !f[2]) ||
             (i == 5 && !f[1]) || (i == 7 && !f[0])));
      if (!drop) begin
        e[m] = wv(i);
        m++;
      end
    end
    return m;
  endfunction
  task automatic wr(input logic [6:0] a, input logic [23:0] d);
    logic [31:0] x;
    host_u.open_sel();
    host_u.xfer({1'b1, a, d}, x);
    host_u.close_sel();
  endtask
  task automatic rd(input logic [6:0] a, output logic [31:0] q);
    logic [31:0] x;
    host_u.open_sel();
    host_u.xfer({1'b0, a, 24'h0}, x);
    host_u.xfer({1'b0, a, 24'h0}, q);
    host_u.close_sel();
  endtask
  task automatic next_req();
    do @(negedge clock);
    while (frame_request !== 1'b1);
  endtask
  task automatic frame_case(input logic [23:0] c, input logic [2:0] f,
                            input logic rdy);
    logic [31:0] w [30];
    logic [31:0] e [10];
    int          m;
    int          k;
    int          hits;
    m = build(fctl(c), f, rdy, e);
    frame_in <= '{ready: rdy, pace_flag: f[2], resp_flag: f[1],
                  eoff_flag: f[0], header: wv(0), chan1: wv(1), chan2: wv(2),
                  chan3: wv(3), pace: wv(4), resp_mag: wv(5),
                  resp_phase: wv(6), eoff: wv(7), pin_state: wv(8),
                  check: wv(9)};
    wr(AF, fctl(c));
    host_u.open_sel();
    for (int i = 0; i < 30; i++)
      host_u.xfer(32'h0, w[i]);
    host_u.close_sel();
    k = 0;
    hits = 0;
    // Second header starts a frame wholly under the new settings
    for (int i = 0; i < 20; i++) begin
      if (w[i] === wv(0))
        hits++;
      if (hits == 2 && k == 0)
        k = i;
    end
    `CHK("header seen", 1'b1, k > 0);
    for (int j = 0; j <= m; j++)
      `CHK("frame word", (j == m) ? wv(0) : e[j], w[k + j]);
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    int          g;
    logic [31:0] x;
    rst = 1'b1;
    is_master = 1'b0;
    frame_in = '0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    `CHK("cfg reset", 6'b000100, cfg);
    host_u.open_sel();
    host_u.xfer({1'b1, 7'h0C, 24'hFFFFFF}, x);
    host_u.xfer({1'b1, 7'h09, 24'h000123}, x);
    host_u.extra_clocks();
    host_u.close_sel();
    rd(7'h0C, x);
    `CHK("unmapped answer", 32'h0, x);
    rd(AF, r);
    `CHK("frame reset", {1'b0, AF, `ECGFOC_FRAME_RST}, r);
    rd(AL, r);
    `CHK("filter reset", {1'b0, AL, `ECGFOC_FILTER_RST}, r);
    for (int i = 0; i < 16; i++) begin
      wr(AL, (24'(i) << 2) & 24'h3C);
      for (int m = 0; m < 2; m++) begin
        is_master <= m[0];
        repeat (8) @(posedge clock);
        `CHK("notch", m ? i[3] : !i[2], cfg.notch_on);
        `CHK("corner", i[1:0], cfg.lowpass_corner);
      end
    end
    rd(AL, r);
    `CHK("filter value", {1'b0, AL, 24'h00003C}, r);
    is_master <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      wr(AF, fctl(24'(i) | (i % 4 == 2 ? 24'h10 : 24'h0)));
      repeat (2) next_req();
      g = 0;
      do begin
        @(negedge clock);
        g++;
      end while (frame_request !== 1'b1);
      `CHK("frame gap", DV[i % 4] * (i < 4 ? 1 : i < 8 ? 2 : 4), g);
      `CHK("rate", i[1:0], cfg.frame_rate);
      `CHK("format", i % 4 > 1, cfg.electrode_fmt);
    end
    frame_case(24'h079000, 3'b111, 1'b1);
    frame_case(24'h404200, 3'b111, 1'b1);
    frame_case(24'h001080, 3'b010, 1'b1);
    frame_case(24'h000000, 3'b000, 1'b0);
    frame_case(24'h001040, 3'b000, 1'b0);
    final_report();
  end
endmodule
